// ---- hw/dcr_params.svh ----
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define DCR_FRAME_BITS      24
`define DCR_ADDR_HI         19
`define DCR_ADDR_LO         16
`define DCR_FIXED_BIT       20
`define DCR_CMD_WR_CFG      4'h4
`define DCR_CMD_RD_CFG      4'hc
`define DCR_CLR_HI          10
`define DCR_CLR_LO          9
`define DCR_SPANEXT_BIT     8
`define DCR_TWOS_BIT        7
`define DCR_TSHUT_BIT       6
`define DCR_REFON_BIT       5
`define DCR_PWRUP_HI        4
`define DCR_PWRUP_LO        3
`define DCR_SPAN_HI         2
`define DCR_SPAN_LO         0
`define DCR_SHORT_BIT       12
`define DCR_BROWN_BIT       11
`define DCR_CFG_MASK        16'h07ff
`define DCR_CFG_RESET       16'h0000
`define DCR_SCLK_MAX_MHZ    50

`endif

// ---- hw/dcr_pkg.sv ----
package dcr_pkg;

    typedef enum logic [1:0]
    {
        DCR_SCALE_ZERO = 2'h0,
        DCR_SCALE_MID  = 2'h1,
        DCR_SCALE_FULL = 2'h3
    } dcr_scale_t;

    typedef enum logic [2:0]
    {
        DCR_SPAN_PM10   = 3'h0,
        DCR_SPAN_U10    = 3'h1,
        DCR_SPAN_PM5    = 3'h2,
        DCR_SPAN_U5     = 3'h3,
        DCR_SPAN_M25_75 = 3'h4,
        DCR_SPAN_PM3    = 3'h5,
        DCR_SPAN_U16    = 3'h6,
        DCR_SPAN_U20    = 3'h7
    } dcr_span_t;

    typedef enum logic [1:0]
    {
        DCR_ST_IDLE  = 2'b00,
        DCR_ST_SHIFT = 2'b01,
        DCR_ST_DONE  = 2'b11
    } dcr_state_t;

endpackage : dcr_pkg

// ---- hw/dcr_frame_if.sv ----
interface dcr_frame_if;
    logic        frame_valid;
    logic [23:0] frame_word;
    logic        frame_start;
    logic [23:0] resp_word;

    modport shifter (output frame_valid, output frame_word, output frame_start,
                     input resp_word);
    modport core    (input frame_valid, input frame_word, input frame_start,
                     output resp_word);
endinterface : dcr_frame_if

// ---- hw/dcr_shifter.sv ----
`include "dcr_params.svh"

module dcr_shifter
    import dcr_pkg::*;
(
    input  wire logic   clk_sys_i,
    input  wire logic   srst_i,
    input  wire logic   sclk_i,
    input  wire logic   sync_n_i,
    input  wire logic   serial_in_pin_i,
    output logic        serial_out_pin_o,
    output logic        serial_out_oe_o,
    dcr_frame_if.shifter fr
);
    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] sclk_s;
    logic [1:0] sync_s;
    logic [1:0] din_s;
    logic       sclk_d;
    logic       sync_d;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sclk_s <= 2'h0;
            sync_s <= 2'h3;
            din_s  <= 2'h0;
            sclk_d <= 1'b0;
            sync_d <= 1'b1;
        end
        else
        begin
            sclk_s <= {sclk_s[0], sclk_i};
            sync_s <= {sync_s[0], sync_n_i};
            din_s  <= {din_s[0], serial_in_pin_i};
            sclk_d <= sclk_s[1];
            sync_d <= sync_s[1];
        end
    end

    logic rise;
    logic fall;
    logic f_start;
    logic f_end;
    assign rise    = sclk_s[1] & ~sclk_d;
    assign fall    = ~sclk_s[1] & sclk_d;
    assign f_start = ~sync_s[1] & sync_d;
    assign f_end   = sync_s[1] & ~sync_d;

    // ------------------------------------------------------------------------
    // Shift in on rising edge, out on falling edge, MSB first
    // ------------------------------------------------------------------------
    logic [23:0] sh_in;
    logic [23:0] sh_out;
    logic [4:0]  cnt;
    dcr_state_t  state;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            state          <= DCR_ST_IDLE;
            sh_in          <= 24'h0;
            cnt            <= 5'h0;
            fr.frame_valid <= 1'b0;
            fr.frame_word  <= 24'h0;
        end
        else
        begin
            fr.frame_valid <= 1'b0;
            case (state)
                DCR_ST_IDLE:
                begin
                    if (f_start)
                    begin
                        state <= DCR_ST_SHIFT;
                        cnt   <= 5'h0;
                    end
                end
                DCR_ST_SHIFT:
                begin
                    if (rise && !sync_s[1])
                    begin
                        sh_in <= {sh_in[22:0], din_s[1]};
                        cnt   <= cnt + 5'h1;
                    end
                    if (f_end)
                        state <= DCR_ST_DONE;
                end
                DCR_ST_DONE:
                begin
                    // Frames whose bit count is not 24 modulo 32 are dropped whole; the 5-bit cnt wraps
                    fr.frame_valid <= (cnt == 5'(`DCR_FRAME_BITS));
                    fr.frame_word  <= sh_in;
                    state          <= DCR_ST_IDLE;
                end
                default: state <= DCR_ST_IDLE;
            endcase
        end
    end

    assign fr.frame_start = f_start;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sh_out           <= 24'h0;
            serial_out_pin_o <= 1'b0;
        end
        else if (f_start)
        begin
            sh_out           <= {fr.resp_word[22:0], 1'b0};
            serial_out_pin_o <= fr.resp_word[23];
        end
        else if (fall && !sync_s[1])
        begin
            sh_out           <= {sh_out[22:0], 1'b0};
            serial_out_pin_o <= sh_out[23];
        end
    end

    assign serial_out_oe_o = ~sync_s[1];

endmodule : dcr_shifter

// ---- hw/dcr_core.sv ----
// Operation
// - Write frame: code 0100, fields in low bits
// - Overrange bit extends span by five percent
// - Bipolar coding bit selects twos complement input
// - Twos complement equals binary with MSB inverted
// - Thermal bit powers down digital supply overtemp
// - Reference bit switches internal reference
// - Three-bit field picks one of eight spans
// - Readback request code 1100, data ignored
// - Response shifts out next frame, MSB first
// - Response echoes 1100, flags at 12, 11
// - Short flag sets on short, clears on write
// - Brownout flag sets on event, clears on write
// - 24-bit frames, MSB first, host clock
// - Output clamped until first configuration write
// - Alert low until first configuration write
`include "dcr_params.svh"

module dcr_core
    import dcr_pkg::*;
(
    input  wire logic   clk_sys_i,
    input  wire logic   srst_i,
    input  wire logic   sclk_i,
    input  wire logic   sync_n_i,
    input  wire logic   serial_in_pin_i,
    input  wire logic   short_det_i,
    input  wire logic   brownout_det_i,
    input  wire logic   overtemp_i,
    input  wire logic   [15:0] dac_code_i,
    output logic        serial_out_pin_o,
    output logic        serial_out_oe_o,
    output logic        alert_n_o,
    output logic        output_clamp_o,
    output logic        buffer_power_o,
    output logic        span_extend_en_o,
    output logic        bipolar_twos_comp_o,
    output logic        thermal_shutdown_en_o,
    output logic        digital_supply_off_o,
    output logic        internal_ref_on_o,
    output dcr_span_t   output_span_sel_o,
    output dcr_scale_t  clear_scale_o,
    output dcr_scale_t  powerup_scale_o,
    output logic        span_bipolar_o,
    output logic [15:0] dac_code_binary_o
);
    // ------------------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------------------
    dcr_frame_if fr ();

    dcr_shifter u_shifter
    (
        .clk_sys_i        (clk_sys_i),
        .srst_i           (srst_i),
        .sclk_i           (sclk_i),
        .sync_n_i         (sync_n_i),
        .serial_in_pin_i  (serial_in_pin_i),
        .serial_out_pin_o (serial_out_pin_o),
        .serial_out_oe_o  (serial_out_oe_o),
        .fr               (fr.shifter)
    );

    function automatic dcr_scale_t decode_scale(input logic [1:0] sel);
        if (sel == 2'h0)
            return DCR_SCALE_ZERO;
        else if (sel == 2'h1)
            return DCR_SCALE_MID;
        else
            return DCR_SCALE_FULL;
    endfunction : decode_scale

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    logic [3:0] cmd;
    logic       fixed_ok;
    logic       wr_cfg;
    logic       rd_cfg;
    assign cmd      = fr.frame_word[`DCR_ADDR_HI:`DCR_ADDR_LO];
    assign fixed_ok = ~fr.frame_word[`DCR_FIXED_BIT];
    assign wr_cfg   = fr.frame_valid & fixed_ok & (cmd == `DCR_CMD_WR_CFG);
    assign rd_cfg   = fr.frame_valid & fixed_ok & (cmd == `DCR_CMD_RD_CFG);

    // ------------------------------------------------------------------------
    // Configuration and status register
    // ------------------------------------------------------------------------
    logic [15:0] output_config_status;
    logic        configured;
    logic        short_detect_flag;
    logic        brownout_flag;
    logic        rd_pending;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            output_config_status <= `DCR_CFG_RESET;
        else if (wr_cfg)
            output_config_status <= fr.frame_word[15:0] & `DCR_CFG_MASK;
    end

    // Set wins over the write that clears
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            short_detect_flag <= 1'b0;
            brownout_flag     <= 1'b0;
        end
        else
        begin
            if (short_det_i)
                short_detect_flag <= 1'b1;
            else if (wr_cfg)
                short_detect_flag <= 1'b0;
            if (brownout_det_i)
                brownout_flag <= 1'b1;
            else if (wr_cfg)
                brownout_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            configured <= 1'b0;
        else if (wr_cfg)
            configured <= 1'b1;
    end

    // Request armed until the next frame starts
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            rd_pending <= 1'b0;
        else if (rd_cfg)
            rd_pending <= 1'b1;
        else if (fr.frame_start)
            rd_pending <= 1'b0;
    end

    // Response is sampled at the next frame start
    always_comb
    begin
        fr.resp_word = 24'h0;
        if (rd_pending)
        begin
            fr.resp_word[`DCR_ADDR_HI:`DCR_ADDR_LO] = `DCR_CMD_RD_CFG;
            fr.resp_word[`DCR_SHORT_BIT] = short_detect_flag;
            fr.resp_word[`DCR_BROWN_BIT] = brownout_flag;
            fr.resp_word[10:0]         = output_config_status[10:0];
        end
    end

    // ------------------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------------------
    logic over_temp_s0;
    logic over_temp_s1;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            over_temp_s0 <= 1'b0;
            over_temp_s1 <= 1'b0;
        end
        else
        begin
            over_temp_s0 <= overtemp_i;
            over_temp_s1 <= over_temp_s0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            span_extend_en_o      <= 1'b0;
            bipolar_twos_comp_o   <= 1'b0;
            thermal_shutdown_en_o <= 1'b0;
            internal_ref_on_o     <= 1'b0;
            output_span_sel_o     <= DCR_SPAN_PM10;
            clear_scale_o         <= DCR_SCALE_ZERO;
            powerup_scale_o       <= DCR_SCALE_ZERO;
            digital_supply_off_o  <= 1'b0;
            alert_n_o             <= 1'b0;
            output_clamp_o        <= 1'b1;
            buffer_power_o        <= 1'b0;
        end
        else
        begin
            span_extend_en_o      <= output_config_status[`DCR_SPANEXT_BIT];
            bipolar_twos_comp_o   <= output_config_status[`DCR_TWOS_BIT];
            thermal_shutdown_en_o <= output_config_status[`DCR_TSHUT_BIT];
            internal_ref_on_o     <= output_config_status[`DCR_REFON_BIT];
            output_span_sel_o     <=
                dcr_span_t'(output_config_status[`DCR_SPAN_HI:`DCR_SPAN_LO]);
            clear_scale_o   <=
                decode_scale(output_config_status[`DCR_CLR_HI:`DCR_CLR_LO]);
            powerup_scale_o <=
                decode_scale(output_config_status[`DCR_PWRUP_HI:`DCR_PWRUP_LO]);
            // Latched: the device stays down once shut off
            if (over_temp_s1 && output_config_status[`DCR_TSHUT_BIT])
                digital_supply_off_o <= 1'b1;
            alert_n_o      <= configured & ~over_temp_s1;
            output_clamp_o <= ~configured;
            buffer_power_o <= configured;
        end
    end

    // ------------------------------------------------------------------------
    // Input code conversion
    // ------------------------------------------------------------------------
    logic is_bipolar;
    always_comb
    begin
        case (output_span_sel_o)
            DCR_SPAN_PM10, DCR_SPAN_PM5, DCR_SPAN_M25_75, DCR_SPAN_PM3: is_bipolar = 1'b1;
            default: is_bipolar = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            span_bipolar_o    <= 1'b0;
            dac_code_binary_o <= 16'h0;
        end
        else
        begin
            span_bipolar_o <= is_bipolar;
            if (is_bipolar && bipolar_twos_comp_o)
                dac_code_binary_o <= {~dac_code_i[15], dac_code_i[14:0]};
            else
                dac_code_binary_o <= dac_code_i;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_wr_loads;
        @(posedge clk_sys_i) disable iff (srst_i)
        wr_cfg |=> (output_config_status == ($past(fr.frame_word[15:0]) & 16'h07ff));
    endproperty
    a_wr_loads: assert property (p_wr_loads) else $error("cfg not loaded");

    property p_ovr;
        @(posedge clk_sys_i) disable iff (srst_i)
        wr_cfg |-> ##2 span_extend_en_o == $past(fr.frame_word[8], 2);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrange mismatch");

    property p_twos;
        @(posedge clk_sys_i) disable iff (srst_i)
        (is_bipolar && bipolar_twos_comp_o) |=>
            dac_code_binary_o[15] != $past(dac_code_i[15]);
    endproperty
    a_twos: assert property (p_twos) else $error("twos complement wrong");

    property p_sc_clear;
        @(posedge clk_sys_i) disable iff (srst_i)
        (wr_cfg && !short_det_i) |=> !short_detect_flag;
    endproperty
    a_sc_clear: assert property (p_sc_clear) else $error("short flag kept");

    property p_bo_set;
        @(posedge clk_sys_i) disable iff (srst_i)
        brownout_det_i |=> brownout_flag;
    endproperty
    a_bo_set: assert property (p_bo_set) else $error("brownout not set");

    property p_clamp;
        @(posedge clk_sys_i) disable iff (srst_i)
        !configured |=> output_clamp_o && !buffer_power_o;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp released early");

    property p_alert;
        @(posedge clk_sys_i) disable iff (srst_i)
        (wr_cfg && !over_temp_s1 && !overtemp_i && !over_temp_s0) |-> ##2 alert_n_o;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not raised");

    property p_resp;
        @(posedge clk_sys_i) disable iff (srst_i)
        rd_cfg |=> fr.resp_word[19:16] == 4'hc && fr.resp_word[20] == 1'b0;
    endproperty
    a_resp: assert property (p_resp) else $error("response address wrong");

    property p_range;
        @(posedge clk_sys_i) disable iff (srst_i)
        wr_cfg |-> ##2 output_span_sel_o == dcr_span_t'($past(fr.frame_word[2:0], 2));
    endproperty
    a_range: assert property (p_range) else $error("range mismatch");

endmodule : dcr_core

// ---- verification/dcr_host_model.sv ----
// ----------------------------------------------------------------------------
// Host side of the serial programming link
// ----------------------------------------------------------------------------
module dcr_host_model
(
    input  wire logic clk_sys_i,
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      sync_n_o,
    output logic      din_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Serial clock idles low and stands still between frames
    initial
    begin
        sclk_o   = 1'b0;
        sync_n_o = 1'b1;
        din_o    = 1'b0;
    end

    // Half period in system cycles; data moves on the falling edge only
    task automatic xfer(input logic [23:0] w, input int half, output logic [23:0] r);
        r = 24'h000000;
        @(negedge clk_sys_i);
        sync_n_o <= 1'b0;
        for (int b = 23; b >= 0; b--)
        begin
            din_o <= w[b];
            repeat (half) @(negedge clk_sys_i);
            r[b] = dout_i;
            sclk_o <= 1'b1;
            repeat (half) @(negedge clk_sys_i);
            sclk_o <= 1'b0;
        end
        repeat (half) @(negedge clk_sys_i);
        sync_n_o <= 1'b1;
        // Released data line must not look like a held bit
        din_o <= ~w[0];
        repeat (20) @(negedge clk_sys_i);
    endtask : xfer
endmodule : dcr_host_model

// ---- verification/dac_control_register_tb.sv ----
module dac_control_register_tb
    import dcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        short_det_i = 1'b0;
    logic        brownout_det_i = 1'b0;
    logic        overtemp_i = 1'b0;
    logic [15:0] dac_code_i = 16'h0000;
    logic        sclk, sync_n, din, dout_pin, dout, oe, alert_n, clamp, bufp;
    logic        ext_en, twos, tshut, supply_off, refon, bip;
    dcr_span_t   span;
    dcr_scale_t  clr_sc, pu_sc;
    logic [15:0] code_bin;
    logic [23:0] rx;
    int          bad_count = 0;
    int          n_compared = 0;

    initial
    begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    dcr_core dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sclk_i(sclk), .sync_n_i(sync_n),
        .serial_in_pin_i(din), .short_det_i(short_det_i), .brownout_det_i(brownout_det_i),
        .overtemp_i(overtemp_i), .dac_code_i(dac_code_i), .serial_out_pin_o(dout_pin),
        .serial_out_oe_o(oe), .alert_n_o(alert_n), .output_clamp_o(clamp),
        .buffer_power_o(bufp), .span_extend_en_o(ext_en), .bipolar_twos_comp_o(twos),
        .thermal_shutdown_en_o(tshut), .digital_supply_off_o(supply_off),
        .internal_ref_on_o(refon), .output_span_sel_o(span), .clear_scale_o(clr_sc),
        .powerup_scale_o(pu_sc), .span_bipolar_o(bip), .dac_code_binary_o(code_bin));

    // Undriven line reads inverted, so a sample taken while disabled fails
    assign dout = oe ? dout_pin : ~dout_pin;

    dcr_host_model host (.clk_sys_i(clk_sys_i), .dout_i(dout), .sclk_o(sclk),
        .sync_n_o(sync_n), .din_o(din));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset;
        @(negedge clk_sys_i);
        srst_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        srst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
    endtask : do_reset

    // Don't-care and ignored bits are sent as ones on purpose
    task automatic write_cfg(input logic [10:0] d);
        host.xfer({3'h7, 1'b0, 4'h4, 5'h1f, d}, 10, rx);
    endtask : write_cfg

    task automatic read_cfg(input logic sc, input logic bo, input logic [10:0] d);
        host.xfer({3'h7, 1'b0, 4'hc, 16'hffff}, 10, rx);
        host.xfer(24'h000000, 10, rx);
        check("readback", rx, {4'h0, 4'hc, 3'h0, sc, bo, d});
    endtask : read_cfg

    function automatic logic [1:0] scale(input logic [1:0] v);
        return (v == 2'h0) ? 2'h0 : ((v == 2'h1) ? 2'h1 : 2'h3);
    endfunction : scale

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        do_reset();
        check("clamp", 24'(clamp), 24'h1);
        check("buffer", 24'(bufp), 24'h0);
        check("alert_n", 24'(alert_n), 24'h0);
        check("oe", 24'(oe), 24'h0);
        read_cfg(1'b0, 1'b0, 11'h000);
        // A readback is not a configuration write
        check("clamp after read", 24'(clamp), 24'h1);
        check("alert after read", 24'(alert_n), 24'h0);
    endtask : t_reset

    task automatic t_fields;
        logic [10:0] d;
        for (int i = 0; i < 8; i++)
        begin
            d = {i[1:0], i[0], i[1], i[2], ~i[0], ~i[1:0], i[2:0]};
            do_reset();
            write_cfg(d);
            check("span", 24'(span), 24'(i));
            check("clear", 24'(clr_sc), 24'(scale(d[10:9])));
            check("powerup", 24'(pu_sc), 24'(scale(d[4:3])));
            check("span_ext", 24'(ext_en), 24'(d[8]));
            check("twos", 24'(twos), 24'(d[7]));
            check("tshut", 24'(tshut), 24'(d[6]));
            check("refon", 24'(refon), 24'(d[5]));
            check("bipolar", 24'(bip), 24'(i == 0 || i == 2 || i == 4 || i == 5));
            check("clamp", 24'(clamp), 24'h0);
            check("buffer", 24'(bufp), 24'h1);
            check("alert_n", 24'(alert_n), 24'h1);
            read_cfg(1'b0, 1'b0, d);
        end
    endtask : t_fields

    task automatic t_refuse;
        do_reset();
        write_cfg(11'h5a3);
        host.xfer({3'h0, 1'b1, 4'h4, 16'h07ff}, 5, rx);
        host.xfer({3'h0, 1'b0, 4'h5, 16'h07ff}, 5, rx);
        read_cfg(1'b0, 1'b0, 11'h5a3);
    endtask : t_refuse

    task automatic t_flags;
        @(negedge clk_sys_i);
        short_det_i = 1'b1;
        @(negedge clk_sys_i);
        short_det_i = 1'b0;
        read_cfg(1'b1, 1'b0, 11'h5a3);
        brownout_det_i = 1'b1;
        @(negedge clk_sys_i);
        brownout_det_i = 1'b0;
        read_cfg(1'b1, 1'b1, 11'h5a3);
        write_cfg(11'h5a3);
        read_cfg(1'b0, 1'b0, 11'h5a3);
    endtask : t_flags

    task automatic t_code;
        logic [10:0] d [3] = '{11'h080, 11'h000, 11'h081};
        logic [15:0] in [2] = '{16'h0000, 16'h7fff};
        for (int k = 0; k < 3; k++)
        begin
            do_reset();
            write_cfg(d[k]);
            for (int j = 0; j < 2; j++)
            begin
                dac_code_i = in[j];
                repeat (3) @(negedge clk_sys_i);
                check("code", 24'(code_bin), 24'(in[j] ^ {k == 0, 15'h0}));
            end
        end
    endtask : t_code

    task automatic t_thermal;
        do_reset();
        write_cfg(11'h000);
        overtemp_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        check("supply kept", 24'(supply_off), 24'h0);
        overtemp_i = 1'b0;
        write_cfg(11'h040);
        overtemp_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        overtemp_i = 1'b0;
        repeat (10) @(negedge clk_sys_i);
        check("supply off", 24'(supply_off), 24'h1);
    endtask : t_thermal

    // ------------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------------
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    initial
    begin
        t_reset();
        t_fields();
        t_refuse();
        t_flags();
        t_code();
        t_thermal();
        conclude();
    end

    // About 40 frames of some 520 cycles each, with wide margin
    initial
    begin
        #600us;
        bad_count++;
        conclude();
    end
endmodule : dac_control_register_tb
